// *** core/rtc_axil_slave.sv ***
// Purpose: AXI4-Lite slave that turns bus transfers into register strobes
// Assumes: One write and one read outstanding at most
// Notes: Response one cycle after address and data are both taken
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_axil_slave (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire rtc_pkg::rtc_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire rtc_pkg::rtc_data_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire rtc_pkg::rtc_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output rtc_pkg::rtc_data_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	rtc_reg_if.slave regs
);
	import rtc_pkg::*;

	rtc_slave_t q;
	rtc_slave_t d;

	always_comb begin
		d = q;
		regs.wrEn = 1'b0;
		regs.rdEn = 1'b0;
		regs.rdAddr = s_axi_araddr;
		if (s_axi_awvalid && q.awready) begin
			d.awAddr = s_axi_awaddr;
			d.awready = 1'b0;
		end
		if (s_axi_wvalid && q.wready) begin
			d.wData = s_axi_wdata;
			d.wStrb = s_axi_wstrb;
			d.wready = 1'b0;
		end
		// Address and data may arrive in either order; fire once both are held
		if (!d.awready && !d.wready && !q.bvalid) begin
			regs.wrEn = clkEn;
			d.bvalid = 1'b1;
			d.bresp = regs.wrOk ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
		if (s_axi_arvalid && q.arready) begin
			regs.rdEn = clkEn;
			d.rdata = regs.rdOk ? regs.rdData : '0;
			d.rresp = regs.rdOk ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
			d.rvalid = 1'b1;
			d.arready = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
	end

	assign regs.wrAddr = d.awAddr;
	assign regs.wrData = d.wData;
	assign regs.wrStrb = d.wStrb;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;

endmodule : rtc_axil_slave

// *** core/rtc_defs.svh ***
// Purpose: Constants for the reload timer/counter block
// Assumes: Included by bare name from the package and the design modules
// Notes: Offsets are byte addresses on the register bus
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define RTC_ADDR_W 8
`define RTC_DATA_W 32

`define RTC_OFF_CTRL 8'h00
`define RTC_OFF_COUNT 8'h04
`define RTC_OFF_RELOAD 8'h08
`define RTC_OFF_IRQ_EN 8'h0C
`define RTC_OFF_VEC_ACK 8'h10
`define RTC_OFF_STATUS 8'h14

`define RTC_CTRL_GATE 7
`define RTC_CTRL_SRC 6
`define RTC_CTRL_TF 5
`define RTC_CTRL_RUN 4
`define RTC_CTRL_EFA 3
`define RTC_CTRL_TTA 2
`define RTC_CTRL_EFB 1
`define RTC_CTRL_TTB 0

`define RTC_IRQ_TIMER 0
`define RTC_IRQ_EXTA 1
`define RTC_IRQ_EXTB 2

`define RTC_CTRL_RST 8'h00
`define RTC_COUNT_RST 16'h0000
`define RTC_RELOAD_RST 16'h0000
`define RTC_IRQ_EN_RST 3'h0
`define RTC_COUNT_MAX 16'hFFFF

`define RTC_OSC_DIV 12
`define RTC_SAMPLE_PHASE 6

`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2

`endif

// *** core/rtc_pkg.sv ***
// Purpose: Types shared by the reload timer/counter modules
// Assumes: rtc_defs.svh supplies the widths
// Notes: Each module keeps all its state in one struct from here
`include "rtc_defs.svh"

package rtc_pkg;

	typedef logic [`RTC_ADDR_W-1:0] rtc_addr_t;
	typedef logic [`RTC_DATA_W-1:0] rtc_data_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		rtc_data_t rdata;
		rtc_addr_t awAddr;
		rtc_data_t wData;
		logic [3:0] wStrb;
	} rtc_slave_t;

	typedef struct packed {
		logic [3:0] phase;
		logic [15:0] count;
		logic [15:0] reload;
		logic [7:0] ctrl;
		logic [2:0] irqEn;
		logic [2:0] syncT;
		logic [2:0] syncA;
		logic [2:0] syncB;
		logic pinT;
		logic pinA;
		logic pinB;
		logic prevA;
		logic prevB;
		logic lastSample;
		logic [2:0] irq;
	} rtc_core_t;

endpackage : rtc_pkg

// *** core/rtc_reg_if.sv ***
// Purpose: Register access path between the bus slave and the timer core
// Assumes: Single clock; strobes are one-cycle pulses
// Notes: Read data is combinational from the core, registered by the slave
`timescale 1ns/1ps

interface rtc_reg_if;
	import rtc_pkg::*;
	logic wrEn;
	rtc_addr_t wrAddr;
	rtc_data_t wrData;
	logic [3:0] wrStrb;
	logic wrOk;
	logic rdEn;
	rtc_addr_t rdAddr;
	rtc_data_t rdData;
	logic rdOk;

	modport slave (output wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		input wrOk, rdData, rdOk);
	modport core (input wrEn, wrAddr, wrData, wrStrb, rdEn, rdAddr,
		output wrOk, rdData, rdOk);
endinterface : rtc_reg_if

// *** core/rtc_timer.sv ***
// Purpose: 16-bit auto-reload timer/counter with external interrupt flags
// Assumes: ref_clk is the oscillator; a machine cycle is twelve of its periods
// Notes: Registers reached over AXI4-Lite through rtc_axil_slave
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rtc_defs.svh"

module rtc_timer #(
	parameter int unsigned OSC_DIV = `RTC_OSC_DIV,
	parameter int unsigned SAMPLE_PHASE = `RTC_SAMPLE_PHASE
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic countInputPin,
	input wire logic extIrqPinA,
	input wire logic extIrqPinB,
	input wire rtc_pkg::rtc_addr_t s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire rtc_pkg::rtc_data_t s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire rtc_pkg::rtc_addr_t s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output rtc_pkg::rtc_data_t s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic timerIrq,
	output logic extIrqA,
	output logic extIrqB
);
	import rtc_pkg::*;

	// Phase counter is four bits, so OSC_DIV may not exceed sixteen
	localparam logic [3:0] LAST_PHASE = 4'(OSC_DIV - 1);
	localparam logic [3:0] SAMPLE_AT = 4'(SAMPLE_PHASE);

	rtc_core_t q;
	rtc_core_t d;

	rtc_reg_if regs ();

	rtc_axil_slave u_slave (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.clkEn(clkEn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regs(regs)
	);

	// Byte address to its word; low address bits are ignored, lanes come from strobes
	function automatic rtc_addr_t wordOf(input rtc_addr_t addr);
		return {addr[`RTC_ADDR_W-1:2], 2'h0};
	endfunction : wordOf

	function automatic logic addrHit(input rtc_addr_t addr);
		rtc_addr_t word;
		word = wordOf(addr);
		return (word == `RTC_OFF_CTRL) || (word == `RTC_OFF_COUNT) ||
			(word == `RTC_OFF_RELOAD) || (word == `RTC_OFF_IRQ_EN) ||
			(word == `RTC_OFF_VEC_ACK) || (word == `RTC_OFF_STATUS);
	endfunction : addrHit

	function automatic logic [15:0] mergeLow(input logic [15:0] old,
		input rtc_data_t data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : mergeLow

	// Unmapped words answer with an error and write nothing
	assign regs.wrOk = addrHit(regs.wrAddr);
	assign regs.rdOk = addrHit(regs.rdAddr);

	always_comb begin
		regs.rdData = '0;
		case (wordOf(regs.rdAddr))
			`RTC_OFF_CTRL: begin
				regs.rdData[7:0] = q.ctrl;
			end
			`RTC_OFF_COUNT: begin
				regs.rdData[15:0] = q.count;
			end
			`RTC_OFF_RELOAD: begin
				regs.rdData[15:0] = q.reload;
			end
			`RTC_OFF_IRQ_EN: begin
				regs.rdData[2:0] = q.irqEn;
			end
			`RTC_OFF_VEC_ACK: begin
				// Acknowledge is a write-only strobe
				regs.rdData = '0;
			end
			`RTC_OFF_STATUS: begin
				// Filtered pin levels, then the registered request outputs
				regs.rdData[5:0] = {q.pinB, q.pinA, q.pinT, q.irq};
			end
			default: begin
				regs.rdData = '0;
			end
		endcase
	end

	always_comb begin
		logic runOk;
		logic tick;
		logic overflow;
		logic fallA;
		logic fallB;
		logic [7:0] wrWord;
		logic wrHit;
		logic [2:0] ack;
		logic sampFall;
		runOk = 1'b0;
		tick = 1'b0;
		overflow = 1'b0;
		fallA = 1'b0;
		fallB = 1'b0;
		sampFall = 1'b0;
		wrWord = wordOf(regs.wrAddr);
		wrHit = regs.wrEn && regs.wrOk;
		ack = 3'h0;
		d = q;

		// Three-stage pin synchronisers; a level is accepted once stages two and three agree
		d.syncT = {q.syncT[1:0], countInputPin};
		d.syncA = {q.syncA[1:0], extIrqPinA};
		d.syncB = {q.syncB[1:0], extIrqPinB};
		if (q.syncT[1] == q.syncT[2]) begin
			d.pinT = q.syncT[2];
		end
		if (q.syncA[1] == q.syncA[2]) begin
			d.pinA = q.syncA[2];
		end
		if (q.syncB[1] == q.syncB[2]) begin
			d.pinB = q.syncB[2];
		end

		// Machine-cycle phase counter, free running
		d.phase = (q.phase == LAST_PHASE) ? 4'h0 : 4'(q.phase + 4'h1);

		// Gate uses the filtered level of pin A, not its edge flag
		runOk = q.ctrl[`RTC_CTRL_RUN] &&
			(!q.ctrl[`RTC_CTRL_GATE] || q.pinA);
		// Sampled in every mode and while stopped, so entering counter mode
		// never pairs a fresh sample with a stale one left from reset
		if (q.phase == SAMPLE_AT) begin
			d.lastSample = q.pinT;
			sampFall = q.lastSample && !q.pinT;
		end
		if (q.ctrl[`RTC_CTRL_SRC]) begin
			tick = sampFall;
		end else begin
			tick = (q.phase == LAST_PHASE);
		end
		tick = tick && runOk;

		// A tick at the top value reloads instead of wrapping through zero
		if (tick) begin
			if (q.count == `RTC_COUNT_MAX) begin
				d.count = q.reload;
				overflow = 1'b1;
			end else begin
				d.count = q.count + 16'h0001;
			end
		end

		// Software writes override the count; flag sets below still win
		if (wrHit) begin
			case (wrWord)
				`RTC_OFF_CTRL: begin
					if (regs.wrStrb[0]) begin
						d.ctrl = regs.wrData[7:0];
					end
				end
				`RTC_OFF_COUNT: begin
					d.count = mergeLow(d.count, regs.wrData, regs.wrStrb);
				end
				`RTC_OFF_RELOAD: begin
					d.reload = mergeLow(q.reload, regs.wrData, regs.wrStrb);
				end
				`RTC_OFF_IRQ_EN: begin
					if (regs.wrStrb[0]) begin
						d.irqEn = regs.wrData[2:0];
					end
				end
				`RTC_OFF_VEC_ACK: begin
					if (regs.wrStrb[0]) begin
						ack = regs.wrData[2:0];
					end
				end
				default: begin
					ack = 3'h0;
				end
			endcase
		end

		// Vector acknowledge stands in for the processor entering the handler
		if (ack[`RTC_IRQ_TIMER]) begin
			d.ctrl[`RTC_CTRL_TF] = 1'b0;
		end
		// Level mode ignores the acknowledge: the flag follows the pin
		if (ack[`RTC_IRQ_EXTA] && q.ctrl[`RTC_CTRL_TTA]) begin
			d.ctrl[`RTC_CTRL_EFA] = 1'b0;
		end
		if (ack[`RTC_IRQ_EXTB] && q.ctrl[`RTC_CTRL_TTB]) begin
			d.ctrl[`RTC_CTRL_EFB] = 1'b0;
		end

		// Placed after the clears so a flag set in the same cycle wins
		if (overflow) begin
			d.ctrl[`RTC_CTRL_TF] = 1'b1;
		end

		// External requests are active low: a falling edge or a low level
		d.prevA = q.pinA;
		d.prevB = q.pinB;
		fallA = q.prevA && !q.pinA;
		fallB = q.prevB && !q.pinB;
		if (q.ctrl[`RTC_CTRL_TTA]) begin
			if (fallA) begin
				d.ctrl[`RTC_CTRL_EFA] = 1'b1;
			end
		end else begin
			d.ctrl[`RTC_CTRL_EFA] = !q.pinA;
		end
		if (q.ctrl[`RTC_CTRL_TTB]) begin
			if (fallB) begin
				d.ctrl[`RTC_CTRL_EFB] = 1'b1;
			end
		end else begin
			d.ctrl[`RTC_CTRL_EFB] = !q.pinB;
		end

		// Requests are registered so each output leaves a flip-flop
		d.irq[`RTC_IRQ_TIMER] = q.ctrl[`RTC_CTRL_TF] && q.irqEn[`RTC_IRQ_TIMER];
		d.irq[`RTC_IRQ_EXTA] = q.ctrl[`RTC_CTRL_EFA] && q.irqEn[`RTC_IRQ_EXTA];
		d.irq[`RTC_IRQ_EXTB] = q.ctrl[`RTC_CTRL_EFB] && q.irqEn[`RTC_IRQ_EXTB];
	end

	// Clock enable low holds every field, synchronisers included
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{ctrl: `RTC_CTRL_RST, count: `RTC_COUNT_RST,
				reload: `RTC_RELOAD_RST, irqEn: `RTC_IRQ_EN_RST, default: '0};
		end else if (clkEn) begin
			q <= d;
		end
	end

	assign timerIrq = q.irq[`RTC_IRQ_TIMER];
	assign extIrqA = q.irq[`RTC_IRQ_EXTA];
	assign extIrqB = q.irq[`RTC_IRQ_EXTB];

endmodule : rtc_timer

// *** verif/rtc_pin_model.sv ***
// Purpose: Drives the count pin and the two interrupt pins
// Assumes: pins[0] count, pins[1] pin A, pins[2] pin B
// Notes: Levels held 30 cycles so at least two samples see each one
`timescale 1ns/1ps

module rtc_pin_model (
	input wire logic ref_clk,
	output logic [2:0] pins
);
	initial pins = 3'h7;

	task automatic lvl(input int s, input logic v);
		@(posedge ref_clk);
		pins[s] <= v;
	endtask : lvl

	task automatic pulse(input int s, input int n);
		repeat (n) begin
			lvl(s, 1'b0);
			repeat (30) @(posedge ref_clk);
			lvl(s, 1'b1);
			repeat (30) @(posedge ref_clk);
		end
	endtask : pulse
endmodule : rtc_pin_model

// *** verif/rtc_timer_checker.sv ***
// Purpose: Bus and freeze properties seen at the timer block's ports
// Assumes: Single clock ref_clk, reset nrst active low
// Notes: Bound to every rtc_timer instance
`timescale 1ns/1ps

module rtc_timer_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clkEn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_rresp,
	input wire rtc_pkg::rtc_data_t s_axi_rdata,
	input wire logic timerIrq,
	input wire logic extIrqA,
	input wire logic extIrqB
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	AST_WR_RESP: assert property (clkEn && s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
	AST_RD_RESP: assert property (clkEn && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_B_DONE: assert property (clkEn && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
		&& s_axi_awready && s_axi_wready) else $error("write slot not freed");
	AST_R_DONE: assert property (clkEn && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
		&& s_axi_arready) else $error("read answer repeated");
	AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == '0)
		else $error("error read carries data");
	// Gated clock must freeze the three request outputs and the write response valid
	AST_FREEZE: assert property (!clkEn |=> $stable({timerIrq, extIrqA, extIrqB, s_axi_bvalid}))
		else $error("outputs moved while frozen");
endmodule : rtc_timer_checker

bind rtc_timer rtc_timer_checker chk (.ref_clk, .nrst, .clkEn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rresp, .s_axi_rdata, .timerIrq, .extIrqA, .extIrqB);

// *** verif/tb.sv ***
// Purpose: Register-level tests of the reload timer/counter
// Assumes: 50 MHz ref_clk, write strobes all on
// Notes: Count rate measured between two reads exactly 12k cycles apart
`timescale 1ns/1ps

module tb;
	import rtc_pkg::*;
	logic ref_clk = 1'b0, nrst = 1'b0, clkEn = 1'b1;
	logic [2:0] pins;
	rtc_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	rtc_data_t s_axi_wdata = 32'h0, s_axi_rdata, rq;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic timerIrq, extIrqA, extIrqB;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	int nMismatch = 0, checkCount = 0;

	rtc_timer dut (.ref_clk, .nrst, .clkEn, .countInputPin(pins[0]), .extIrqPinA(pins[1]),
		.extIrqPinB(pins[2]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .timerIrq, .extIrqA, .extIrqB);
	rtc_pin_model pm (.ref_clk, .pins);

	initial forever #10 ref_clk = ~ref_clk;
	initial begin
		repeat (20000) @(posedge ref_clk);
		nMismatch++;
		closeOut();
	end

	task automatic closeOut;
		$display("mismatches=%0d checks=%0d", nMismatch, checkCount);
		if (nMismatch == 0 && checkCount > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : closeOut

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checkCount++;
		if (s !== e) begin
			nMismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input rtc_addr_t a, input rtc_data_t v);
		logic aP = 1'b1;
		logic wP = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) aP = 1'b0;
			if (s_axi_wready) wP = 1'b0;
			s_axi_awvalid <= aP;
			s_axi_wvalid <= wP;
		end while (aP || wP);
		do @(posedge ref_clk); while (!s_axi_bvalid);
		rsp = s_axi_bresp;
	endtask : wr

	// Takes exactly two edges, which the rate measurement relies on
	task automatic rd(input rtc_addr_t a, output rtc_data_t v);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		v = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask : rd

	task automatic rc(input rtc_addr_t a, input rtc_data_t e);
		rd(a, rq);
		chk(rq, e);
	endtask : rc

	task automatic meas(input int k, input int f, input rtc_data_t e);
		rtc_data_t a, b;
		rd(8'h04, a);
		repeat (12 * k - 2 - f) @(posedge ref_clk);
		if (f > 0) begin
			clkEn <= 1'b0;
			repeat (f) @(posedge ref_clk);
			clkEn <= 1'b1;
		end
		rd(8'h04, b);
		chk(b - a, e);
	endtask : meas

	initial begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		for (int i = 0; i < 5; i++) rc(8'(4 * i), 32'h0);
		wr(8'h18, 32'h1);
		chk({30'h0, rsp}, 32'h2);
		rc(8'h18, 32'h0);
		chk({30'h0, rsp}, 32'h2);
		wr(8'h04, 32'hFE);
		wr(8'h00, 32'h10);
		meas(5, 0, 32'h5);
		meas(5, 24, 32'h3);
		wr(8'h00, 32'h0);
		meas(2, 0, 32'h0);
		pm.lvl(1, 1'b0);
		repeat (10) @(posedge ref_clk);
		wr(8'h00, 32'h90);
		meas(2, 0, 32'h0);
		pm.lvl(1, 1'b1);
		repeat (10) @(posedge ref_clk);
		meas(2, 0, 32'h2);
		pm.lvl(1, 1'b0);
		wr(8'h00, 32'h10);
		meas(2, 0, 32'h2);
		pm.lvl(1, 1'b1);
		wr(8'h00, 32'h0);
		wr(8'h08, 32'hABCD);
		wr(8'h04, 32'hFFFF);
		wr(8'h00, 32'h50);
		pm.pulse(0, 1);
		rc(8'h04, 32'hABCD);
		rc(8'h08, 32'hABCD);
		rc(8'h00, 32'h70);
		chk({31'h0, timerIrq}, 32'h0);
		wr(8'h0C, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, timerIrq}, 32'h1);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge ref_clk);
		rc(8'h00, 32'h50);
		chk({31'h0, timerIrq}, 32'h0);
		pm.pulse(0, 3);
		rc(8'h04, 32'hABD0);
		wr(8'h00, 32'h5);
		wr(8'h0C, 32'h6);
		pm.pulse(1, 1);
		pm.pulse(2, 1);
		rc(8'h00, 32'hF);
		chk({30'h0, extIrqB, extIrqA}, 32'h3);
		rc(8'h14, 32'h3E);
		wr(8'h10, 32'h6);
		rc(8'h00, 32'h5);
		wr(8'h00, 32'h0);
		pm.lvl(1, 1'b0);
		pm.lvl(2, 1'b0);
		repeat (10) @(posedge ref_clk);
		rc(8'h00, 32'hA);
		chk({30'h0, extIrqB, extIrqA}, 32'h3);
		pm.lvl(1, 1'b1);
		pm.lvl(2, 1'b1);
		repeat (10) @(posedge ref_clk);
		rc(8'h00, 32'h0);
		closeOut();
	end
endmodule : tb
